/* File: core/iavs_core.sv */
// Purpose: eight-input priority interrupt controller core with acknowledge
//          sequencing for call mode and pointer mode, plus cascade logic
// Assumes: all pins asynchronous to clk, strobes held several clocks
// Notes:   fixed priority only; rotation and nested modes not built
//
// Implementation choices: the address-and-strobe port and the address map.
`timescale 1ns/1ps
`include "iavs_cfg.svh"

module iavs_sync #(
   parameter int         W    = 1,
   parameter logic [W-1:0] INIT = '0
) (
   input  wire logic         clk,
   input  wire logic         rst_n,
   input  wire logic [W-1:0] d,
   output logic      [W-1:0] q
);
   logic [W-1:0] meta_q;
   // two-stage synchroniser
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         meta_q <= INIT;
         q      <= INIT;
      end else begin
         meta_q <= d;
         q      <= meta_q;
      end
   end
endmodule // iavs_sync

module iavs_core
   import iavs_pkg::*;
(
   // clock and reset
   input  wire logic       clk,
   input  wire logic       rst_n,
   // host port
   input  wire logic       cs_n,
   input  wire logic       wr_n,
   input  wire logic       rd_n,
   input  wire logic       reg_select,
   input  wire logic [7:0] data_in,
   output logic      [7:0] data_out,
   output logic            data_oe,
   // acknowledge and interrupt
   input  wire logic       ack_strobe_n,
   output logic            interrupt_out,
   // requests
   input  wire logic [7:0] request_input,
   // cascade
   input  wire logic [2:0] cascade_in,
   output logic      [2:0] cascade_out,
   output logic            cascade_oe,
   input  wire logic       slave_prog_buf_enable
);
   // -----------------------------------------------------------------
   // pin synchronisers
   // -----------------------------------------------------------------
   logic [2:0] strb_s;
   logic [8:0] hdat_s;
   logic       ack_s, master_s;
   logic [7:0] req_s;
   logic [2:0] cas_s;

   iavs_sync #(.W(3), .INIT(3'h7)) u_strb (.clk(clk), .rst_n(rst_n),
      .d({cs_n, wr_n, rd_n}), .q(strb_s));
   iavs_sync #(.W(9)) u_hdat (.clk(clk), .rst_n(rst_n),
      .d({reg_select, data_in}), .q(hdat_s));
   iavs_sync #(.W(1), .INIT(1'b1)) u_ack (.clk(clk), .rst_n(rst_n),
      .d(ack_strobe_n), .q(ack_s));
   iavs_sync #(.W(1), .INIT(1'b1)) u_spen (.clk(clk), .rst_n(rst_n),
      .d(slave_prog_buf_enable), .q(master_s));
   iavs_sync #(.W(8)) u_req (.clk(clk), .rst_n(rst_n),
      .d(request_input), .q(req_s));
   iavs_sync #(.W(3)) u_cas (.clk(clk), .rst_n(rst_n),
      .d(cascade_in), .q(cas_s));

   // -----------------------------------------------------------------
   // state
   // -----------------------------------------------------------------
   iavs_init_t init_q;
   iavs_ack_t  ack_q;
   logic [7:0] request_mask_reg_q, pending_request_reg_q, in_service_reg_q;
   logic [7:0] vector_high_bits_q, casc_q, req_prev_q, data_q;
   logic [2:0] vector_low_base_bits_q, lvl_q, cas_q;
   logic       single_q, ic4_q, ltim_q, adi_q, ptr_q, auto_end_of_service_q;
   logic       smm_q, ris_q, poll_q, spur_q, drive_q, cas_oe_q, int_q;
   logic       wr_act_q, rd_act_q, ack_prev_q;

   // -----------------------------------------------------------------
   // host strobe decode
   // -----------------------------------------------------------------
   logic       rd_act, wr_act, wr_done, rd_done, rsel;
   logic [7:0] cmd;
   logic       w_init1, w_end, w_opt, w_rsel, ready;
   assign wr_act  = ~strb_s[2] & ~strb_s[1];
   assign rd_act  = ~strb_s[2] & ~strb_s[0];
   assign wr_done = wr_act_q & ~wr_act;
   assign rd_done = rd_act_q & ~rd_act;
   assign rsel    = hdat_s[8];
   assign cmd     = hdat_s[7:0];
   assign ready   = (init_q == INIT_READY);
   // select line and data bits choose the word
   assign w_init1 = wr_done & ~rsel & cmd[`IAVS_I1_TAG];
   assign w_end   = wr_done & ~rsel & ~cmd[`IAVS_I1_TAG] & ~cmd[`IAVS_O_SEL] & ready;
   assign w_opt   = wr_done & ~rsel & ~cmd[`IAVS_I1_TAG] & cmd[`IAVS_O_SEL] & ready;
   assign w_rsel  = wr_done & rsel;

   // edge history of strobes and requests
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         wr_act_q   <= 1'b0;
         rd_act_q   <= 1'b0;
         ack_prev_q <= 1'b1;
         req_prev_q <= '0;
      end else begin
         wr_act_q   <= wr_act;
         rd_act_q   <= rd_act;
         ack_prev_q <= ack_s;
         req_prev_q <= req_s;
      end
   end

   // -----------------------------------------------------------------
   // command words
   // -----------------------------------------------------------------
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         init_q                 <= INIT_READY;
         request_mask_reg_q     <= '0;
         vector_high_bits_q     <= '0;
         vector_low_base_bits_q <= '0;
         casc_q                 <= '0;
         single_q               <= 1'b1;
         ic4_q                  <= 1'b0;
         ltim_q                 <= 1'b0;
         adi_q                  <= 1'b0;
         ptr_q                  <= 1'b0;
         auto_end_of_service_q  <= 1'b0;
         smm_q                  <= 1'b0;
         ris_q                  <= 1'b0;
         poll_q                 <= 1'b0;
      end else if (w_init1) begin
         init_q                 <= INIT_W2;
         request_mask_reg_q     <= '0;
         vector_low_base_bits_q <= cmd[`IAVS_I1_VLO];
         single_q               <= cmd[`IAVS_I1_SINGLE];
         ic4_q                  <= cmd[`IAVS_I1_IC4];
         ltim_q                 <= cmd[`IAVS_I1_LTIM];
         adi_q                  <= cmd[`IAVS_I1_ADI];
         ptr_q                  <= 1'b0;
         auto_end_of_service_q  <= 1'b0;
         smm_q                  <= 1'b0;
         ris_q                  <= 1'b0;
         poll_q                 <= 1'b0;
      end else if (w_rsel) begin
         unique case (init_q)
            INIT_W2: begin
               vector_high_bits_q <= cmd;
               init_q <= !single_q ? INIT_W3 : (ic4_q ? INIT_W4 : INIT_READY);
            end
            INIT_W3: begin
               casc_q <= cmd;
               init_q <= ic4_q ? INIT_W4 : INIT_READY;
            end
            INIT_W4: begin
               ptr_q                 <= cmd[`IAVS_I4_PTR];
               auto_end_of_service_q <= cmd[`IAVS_I4_AEOS];
               init_q                <= INIT_READY;
            end
            INIT_READY: request_mask_reg_q <= cmd;
         endcase
      end else if (w_opt) begin
         if (cmd[`IAVS_O3_RR]) ris_q <= cmd[`IAVS_O3_RIS];
         if (cmd[`IAVS_O3_ESMM]) smm_q <= cmd[`IAVS_O3_SMM];
         poll_q <= cmd[`IAVS_O3_POLL];
      end else if (rd_done) begin
         poll_q <= 1'b0;
      end
   end

   // -----------------------------------------------------------------
   // priority resolution
   // -----------------------------------------------------------------
   // lowest index wins, none gives 8
   function automatic logic [3:0] first_set(input logic [7:0] v);
      logic [3:0] r;
      r = `IAVS_NONE_IDX;
      for (int i = 7; i >= 0; i--) begin
         if (v[i]) r = 4'(i);
      end
      return r;
   endfunction

   logic [7:0] pend, eff_svc;
   logic [3:0] hp, hs, hs_raw;
   logic       irq, slave, master_cas, sel;
   assign pend    = pending_request_reg_q & ~request_mask_reg_q;
   // special mask hides in-service bits too
   assign eff_svc = in_service_reg_q & ~(smm_q ? request_mask_reg_q : 8'h00);
   // other inputs resolve regardless of a masked one
   assign hp      = first_set(pend);
   assign hs      = first_set(eff_svc);
   assign hs_raw  = first_set(in_service_reg_q);
   assign irq     = (hp < hs);
   assign slave      = ~single_q & ~master_s;
   assign master_cas = ~single_q & master_s;
   // slave selected only on id match
   assign sel     = slave ? (cas_s == casc_q[2:0]) : ~(master_cas & casc_q[lvl_q]);

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) int_q <= 1'b0;
      else        int_q <= irq;
   end

   // -----------------------------------------------------------------
   // acknowledge sequencing
   // -----------------------------------------------------------------
   logic ack_fall, ack_rise, vec_pulse, take, end_seq;
   assign ack_fall  = ack_prev_q & ~ack_s;
   assign ack_rise  = ~ack_prev_q & ack_s;
   assign vec_pulse = ack_fall & (ack_q == ACK_GOT1);
   // vector pulse moves request into service
   assign take      = vec_pulse & ~spur_q & (sel | ~slave); // master records cascaded input
   assign end_seq   = ack_rise & (ack_q == ACK_LAST);

   // pulse counter, back to idle after last
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         ack_q <= ACK_IDLE;
      end else begin
         unique case (ack_q)
            ACK_IDLE: if (ack_fall) ack_q <= ACK_GOT1;
            // call mode waits for a third pulse
            ACK_GOT1: if (ack_fall) ack_q <= ptr_q ? ACK_LAST : ACK_GOT2;
            ACK_GOT2: if (ack_fall) ack_q <= ACK_LAST;
            ACK_LAST: if (ack_rise) ack_q <= ACK_IDLE;
         endcase
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         lvl_q  <= '0;
         spur_q <= 1'b0;
      end else if (ack_fall && ack_q == ACK_IDLE) begin
         // nothing pending answers as input 7
         spur_q <= (hp == `IAVS_NONE_IDX);
         lvl_q  <= (hp == `IAVS_NONE_IDX) ? `IAVS_SPUR_LEVEL : hp[2:0];
      end
   end

   // pending latch, set wins over clear
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         pending_request_reg_q <= '0;
      end else if (w_init1) begin
         pending_request_reg_q <= '0;
      end else begin
         pending_request_reg_q <= ((pending_request_reg_q & ~(take ? 8'h01 << lvl_q : 8'h00))
            | (ltim_q ? req_s : req_s & ~req_prev_q)) & (ltim_q ? req_s : 8'hff);
      end
   end

   // in-service latch, set wins over clear
   logic [7:0] svc_clr;
   always_comb begin
      svc_clr = '0;
      // end command clears highest or named bit
      if (w_end && cmd[`IAVS_O2_EOS]) begin
         if (cmd[`IAVS_O2_SPEC])        svc_clr = 8'h01 << cmd[`IAVS_O2_LVL];
         else if (hs_raw[3] == 1'b0)    svc_clr = 8'h01 << hs_raw[2:0];
      end
      if (end_seq && auto_end_of_service_q && !spur_q) svc_clr = svc_clr | (8'h01 << lvl_q);
   end
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) in_service_reg_q <= '0;
      else in_service_reg_q <= (in_service_reg_q & ~svc_clr) | (take ? 8'h01 << lvl_q : 8'h00);
   end

   // -----------------------------------------------------------------
   // data bus
   // -----------------------------------------------------------------
   logic [7:0] vec_lo;
   assign vec_lo = adi_q ? {vector_low_base_bits_q, lvl_q, 2'b00}
                         : {vector_low_base_bits_q[2:1], lvl_q, 3'b000};

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         data_q  <= `IAVS_RST_BYTE;
         drive_q <= 1'b0;
      end else if (ack_fall) begin
         unique case (ack_q)
            ACK_IDLE: begin
               // opcode first; pointer mode stays released
               data_q  <= `IAVS_CALL_OPCODE;
               drive_q <= ~ptr_q & ~slave;
            end
            ACK_GOT1: begin
               data_q  <= ptr_q ? {vector_high_bits_q[7:3], lvl_q} : vec_lo;
               drive_q <= sel;
            end
            // high address byte on third pulse
            default: begin
               data_q  <= vector_high_bits_q;
               drive_q <= sel;
            end
         endcase
      end else if (ack_rise) begin
         drive_q <= 1'b0;
      end else if (!drive_q) begin
         data_q <= poll_q ? {irq, 4'h0, hp[2:0]} : rsel ? request_mask_reg_q
                 : ris_q ? in_service_reg_q : pending_request_reg_q;
      end
   end

   // -----------------------------------------------------------------
   // cascade drive
   // -----------------------------------------------------------------
   // master holds slave id for the whole sequence
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cas_q    <= '0;
         cas_oe_q <= 1'b0;
      end else if (ack_fall && ack_q == ACK_IDLE) begin
         cas_oe_q <= master_cas;
         cas_q    <= (hp != `IAVS_NONE_IDX && casc_q[hp[2:0]]) ? hp[2:0] : 3'h0;
      end else if (end_seq) begin
         cas_oe_q <= 1'b0;
      end
   end

   // outputs
   assign data_out      = data_q;
   assign data_oe       = rd_act | (drive_q & ~ack_s);
   assign interrupt_out = int_q;
   assign cascade_out   = cas_q;
   assign cascade_oe    = cas_oe_q;

   // -----------------------------------------------------------------
   // assertions
   // -----------------------------------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);

   property p_int_cause;
      int_q |-> $past(|(pending_request_reg_q & ~request_mask_reg_q));
   endproperty
   a_int_cause: assert property (p_int_cause) else $error("int without unmasked request");
   property p_int_rank;
      $rose(int_q) |-> $past(hp) < $past(hs);
   endproperty
   a_int_rank: assert property (p_int_rank) else $error("int below service level");
   property p_opcode;
      (ack_fall && ack_q == ACK_IDLE && !ptr_q && !slave)
         |=> (data_q == `IAVS_CALL_OPCODE) && drive_q;
   endproperty
   a_opcode: assert property (p_opcode) else $error("no opcode on first pulse");
   property p_ptr_quiet;
      (ack_fall && ack_q == ACK_IDLE && ptr_q) |=> !data_oe || rd_act;
   endproperty
   a_ptr_quiet: assert property (p_ptr_quiet) else $error("bus driven on first pointer pulse");
   property p_take;
      (vec_pulse && !spur_q && sel) |=> in_service_reg_q[lvl_q];
   endproperty
   a_take: assert property (p_take) else $error("in-service not set");
   property p_spur;
      (vec_pulse && spur_q) |=> (lvl_q == 3'h7) && $stable(in_service_reg_q[7]);
   endproperty
   a_spur: assert property (p_spur) else $error("spurious acknowledge set in-service");
   property p_idle;
      end_seq |=> ack_q == ACK_IDLE;
   endproperty
   a_idle: assert property (p_idle) else $error("counter not idle after last pulse");
   property p_cas_hold;
      (ack_q == ACK_GOT1 && master_cas) |-> cascade_oe;
   endproperty
   a_cas_hold: assert property (p_cas_hold) else $error("cascade dropped mid sequence");
   property p_ptr_low;
      (vec_pulse && ptr_q) |=> data_q[2:0] == lvl_q && data_q[7:3] == vector_high_bits_q[7:3];
   endproperty
   a_ptr_low: assert property (p_ptr_low) else $error("pointer bits wrong");
   property p_slave_mis;
      (vec_pulse && slave && cas_s != casc_q[2:0]) |=> !drive_q;
   endproperty
   a_slave_mis: assert property (p_slave_mis) else $error("unselected slave drives");
   property p_aeos;
      (end_seq && auto_end_of_service_q && !spur_q && !take) |=> !in_service_reg_q[$past(lvl_q)];
   endproperty
   a_aeos: assert property (p_aeos) else $error("auto end left in-service");

   c_call: cover property (end_seq && !ptr_q && !spur_q);
   c_ptr:  cover property (end_seq && ptr_q);
   c_spur: cover property (vec_pulse && spur_q);
   c_poll: cover property (rd_done && poll_q);
endmodule // iavs_core

/* File: core/iavs_cfg.svh */
// Purpose: constants of the interrupt acknowledge vector sequencer
// Assumes: included by bare name
// Notes:   positions are bit indices of the host command byte
`ifndef IAVS_CFG_SVH
`define IAVS_CFG_SVH
// -----------------------------------------------------------------
// first-acknowledge opcode and fixed values
// -----------------------------------------------------------------
`define IAVS_CALL_OPCODE  8'hcd
`define IAVS_SPUR_LEVEL   3'h7
`define IAVS_NONE_IDX     4'h8
`define IAVS_RST_BYTE     8'h00
// -----------------------------------------------------------------
// first init word fields (reg_select low)
// -----------------------------------------------------------------
`define IAVS_I1_IC4       0
`define IAVS_I1_SINGLE    1
`define IAVS_I1_ADI       2
`define IAVS_I1_LTIM      3
`define IAVS_I1_TAG       4
`define IAVS_I1_VLO       7:5
// -----------------------------------------------------------------
// fourth init word and operation word fields
// -----------------------------------------------------------------
`define IAVS_I4_PTR       0
`define IAVS_I4_AEOS      1
`define IAVS_O_SEL        3
`define IAVS_O2_SPEC      6
`define IAVS_O2_EOS       5
`define IAVS_O2_LVL       2:0
`define IAVS_O3_RIS       0
`define IAVS_O3_RR        1
`define IAVS_O3_POLL      2
`define IAVS_O3_SMM       5
`define IAVS_O3_ESMM      6
`endif

/* File: core/iavs_pkg.sv */
// Purpose: types of the interrupt acknowledge vector sequencer
// Assumes: nothing
// Notes:   state enums only, constants sit in iavs_cfg.svh
package iavs_pkg;
   // acknowledge pulse progress
   typedef enum logic [1:0] {ACK_IDLE, ACK_GOT1, ACK_GOT2, ACK_LAST} iavs_ack_t;
   // init word sequence
   typedef enum logic [1:0] {INIT_W2, INIT_W3, INIT_W4, INIT_READY} iavs_init_t;
endpackage

/* File: sim/iavs_host.sv */
// Purpose: host processor model for the interrupt acknowledge sequencer
// Assumes: device strobes are asynchronous and need several clocks
// Notes:   a released data bus shows the inverse of its last level
`timescale 1ns/1ps
module iavs_host (
   // clock
   input  wire logic       clk,
   // data bus from device
   input  wire logic [7:0] data_out,
   input  wire logic       data_oe,
   // resolved bus and strobes to device, idle at time zero
   output logic      [7:0] data_in,
   output logic            cs_n         = 1'b1,
   output logic            wr_n         = 1'b1,
   output logic            rd_n         = 1'b1,
   output logic            reg_select   = 1'b0,
   output logic            ack_strobe_n = 1'b1
);
   logic       drv_q  = 1'b0;
   logic [7:0] val_q  = 8'h00;
   logic [7:0] last_q = 8'h00;
   // -----------------------------------------------------------------
   // bus resolution
   // -----------------------------------------------------------------
   // device drive wins, else host, else inverse of last level
   assign data_in = data_oe ? data_out : (drv_q ? val_q : ~last_q);
   // remember the last level that someone drove
   always @(posedge clk) begin
      if (data_oe || drv_q) last_q <= data_in;
   end
   // -----------------------------------------------------------------
   // host cycles
   // -----------------------------------------------------------------
   // command write, data held past the strobe
   task automatic wr(input logic sel, input logic [7:0] b);
      @(posedge clk);
      reg_select <= sel;
      val_q <= b;
      drv_q <= 1'b1;
      cs_n <= 1'b0;
      wr_n <= 1'b0;
      repeat (4) @(posedge clk);
      cs_n <= 1'b1;
      wr_n <= 1'b1;
      repeat (4) @(posedge clk);
      drv_q <= 1'b0;
   endtask
   // status read, sampled late in the strobe
   task automatic rd(input logic sel, output logic [7:0] b);
      @(posedge clk);
      reg_select <= sel;
      cs_n <= 1'b0;
      rd_n <= 1'b0;
      repeat (4) @(posedge clk);
      #1;
      b = data_in;
      @(posedge clk);
      cs_n <= 1'b1;
      rd_n <= 1'b1;
      repeat (4) @(posedge clk);
   endtask
   // one acknowledge pulse
   task automatic pulse(output logic [7:0] b, output logic oe);
      @(posedge clk);
      ack_strobe_n <= 1'b0;
      repeat (5) @(posedge clk);
      #1;
      b = data_in;
      oe = data_oe;
      @(posedge clk);
      ack_strobe_n <= 1'b1;
      repeat (4) @(posedge clk);
   endtask
   task automatic ack_seq(input int n, output logic [7:0] b [3], output logic [2:0] oe);
      for (int i = 0; i < 3; i++) begin
         b[i] = 8'h00;
         oe[i] = 1'b0;
      end
      for (int i = 0; i < n; i++) begin
         pulse(b[i], oe[i]);
      end
   endtask
endmodule // iavs_host

/* File: sim/interrupt_ack_vector_sequencer_tb_top.sv */
// Purpose: self-checking bench for the acknowledge vector sequencer
// Assumes: single controller, cascade lines idle except in t_casc, which drives them
// Notes:   host cycles come from the iavs_host model
`timescale 1ns/1ps
module interrupt_ack_vector_sequencer_tb_top;
   logic       clk;
   logic       rst_n;
   logic [7:0] request_input;
   logic [7:0] data_in;
   logic [7:0] data_out;
   logic       data_oe;
   logic       cs_n;
   logic       wr_n;
   logic       rd_n;
   logic       reg_select;
   logic       ack_strobe_n;
   logic       interrupt_out;
   logic [2:0] cascade_out;
   logic       cascade_oe;
   logic       spen;
   logic [2:0] cas_in;
   int         n_errors;
   int         n_tests;
   int         cycles;
   // -----------------------------------------------------------------
   // instances
   // -----------------------------------------------------------------
   iavs_core dut_u (.clk(clk), .rst_n(rst_n), .cs_n(cs_n), .wr_n(wr_n), .rd_n(rd_n),
      .reg_select(reg_select), .data_in(data_in), .data_out(data_out), .data_oe(data_oe),
      .ack_strobe_n(ack_strobe_n), .interrupt_out(interrupt_out),
      .request_input(request_input), .cascade_in(cas_in), .cascade_out(cascade_out),
      .cascade_oe(cascade_oe), .slave_prog_buf_enable(spen));
   iavs_host host_u (.clk(clk), .data_out(data_out), .data_oe(data_oe), .data_in(data_in),
      .cs_n(cs_n), .wr_n(wr_n), .rd_n(rd_n), .reg_select(reg_select),
      .ack_strobe_n(ack_strobe_n));
   // 25 MHz clock
   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end
   // -----------------------------------------------------------------
   // helpers
   // -----------------------------------------------------------------
   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      n_tests++;
      if (seen !== exp) begin
         n_errors++;
         $display("Error at %0t: got %h expected %h", $time, seen, exp);
      end
   endtask
   // interrupt line after settling
   task automatic irq(input logic exp);
      repeat (8) @(posedge clk);
      chk({7'h00, interrupt_out}, {7'h00, exp});
   endtask
   task automatic close_out;
      $display("tests %0d errors %0d", n_tests, n_errors);
      if (n_errors == 0 && n_tests > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   // -----------------------------------------------------------------
   // scenarios
   // -----------------------------------------------------------------
   task automatic t_mask;
      logic [7:0] b;
      host_u.wr(1'b1, 8'ha5);
      host_u.rd(1'b1, b);
      chk(b, 8'ha5);
      host_u.rd(1'b0, b);
      chk(b, 8'h00);
      $display("t_mask done");
   endtask
   task automatic t_call;
      logic [7:0] b [3];
      logic [7:0] r;
      logic [2:0] oe;
      host_u.wr(1'b0, 8'hb6);
      host_u.wr(1'b1, 8'h12);
      host_u.wr(1'b1, 8'h00);
      @(posedge clk);
      request_input <= 8'h60;
      irq(1'b1);
      host_u.ack_seq(3, b, oe);
      chk(b[0], 8'hcd);
      chk(b[1], 8'hb4);
      chk(b[2], 8'h12);
      chk({5'h00, oe}, 8'h07);
      host_u.wr(1'b0, 8'h0b);
      host_u.rd(1'b0, r);
      chk(r, 8'h20);
      host_u.wr(1'b0, 8'h0a);
      host_u.rd(1'b0, r);
      chk(r, 8'h40);
      irq(1'b0);
      host_u.wr(1'b0, 8'h68);
      host_u.wr(1'b1, 8'h20);
      irq(1'b1);
      host_u.wr(1'b0, 8'h48);
      host_u.wr(1'b1, 8'h40);
      host_u.wr(1'b0, 8'h20);
      irq(1'b0);
      @(posedge clk);
      request_input <= 8'hc0;
      irq(1'b1);
      host_u.rd(1'b0, r);
      chk(r, 8'hc0);
      @(posedge clk);
      request_input <= 8'h00;
      $display("t_call done");
   endtask
   task automatic t_ptr;
      logic [7:0] b [3];
      logic [7:0] r;
      logic [2:0] oe;
      host_u.wr(1'b0, 8'h1b);
      host_u.wr(1'b1, 8'h48);
      host_u.wr(1'b1, 8'h03);
      host_u.wr(1'b1, 8'h00);
      @(posedge clk);
      request_input <= 8'h08;
      irq(1'b1);
      host_u.wr(1'b0, 8'h0c);
      host_u.rd(1'b0, r);
      chk(r, 8'h83);
      host_u.ack_seq(2, b, oe);
      chk({7'h00, oe[0]}, 8'h00);
      chk(b[1], 8'h4b);
      host_u.wr(1'b0, 8'h0b);
      host_u.rd(1'b0, r);
      chk(r, 8'h00);
      @(posedge clk);
      request_input <= 8'h00;
      repeat (8) @(posedge clk);
      host_u.ack_seq(2, b, oe);
      chk(b[1], 8'h4f);
      host_u.rd(1'b0, r);
      chk(r, 8'h00);
      $display("t_ptr done");
   endtask
   task automatic t_casc;
      logic [7:0] b;
      logic [7:0] v [3];
      logic [7:0] r;
      logic       oe;
      logic [2:0] oes;
      // master with a slave on input 2
      host_u.wr(1'b0, 8'h14);
      host_u.wr(1'b1, 8'h00);
      host_u.wr(1'b1, 8'h04);
      @(posedge clk);
      request_input <= 8'h04;
      irq(1'b1);
      host_u.pulse(b, oe);
      chk(b, 8'hcd);
      chk({4'h0, cascade_oe, cascade_out}, 8'h0a);
      host_u.pulse(b, oe);
      chk({7'h00, oe}, 8'h00);
      chk({4'h0, cascade_oe, cascade_out}, 8'h0a);
      host_u.pulse(b, oe);
      chk({4'h0, cascade_oe, cascade_out}, 8'h02);
      host_u.wr(1'b0, 8'h0b);
      host_u.rd(1'b0, r);
      chk(r, 8'h04);
      host_u.wr(1'b0, 8'h20);
      // slave with id 2, first a foreign id on the cascade lines
      spen <= 1'b0;
      cas_in <= 3'h5;
      request_input <= 8'h00;
      host_u.wr(1'b0, 8'h14);
      host_u.wr(1'b1, 8'h00);
      host_u.wr(1'b1, 8'h02);
      @(posedge clk);
      request_input <= 8'h02;
      irq(1'b1);
      host_u.ack_seq(3, v, oes);
      chk({5'h00, oes}, 8'h00);
      @(posedge clk);
      cas_in <= 3'h2;
      host_u.ack_seq(3, v, oes);
      chk({5'h00, oes}, 8'h06);
      chk(v[1], 8'h04);
      spen <= 1'b1;
      request_input <= 8'h00;
      $display("t_casc done");
   endtask
   // -----------------------------------------------------------------
   // main sequence and timeout
   // -----------------------------------------------------------------
   initial begin
      n_errors = 0;
      n_tests = 0;
      rst_n = 1'b0;
      request_input = 8'h00;
      spen = 1'b1;
      cas_in = 3'h0;
      repeat (8) @(posedge clk);
      rst_n <= 1'b1;
      repeat (4) @(posedge clk);
      t_mask;
      t_call;
      t_ptr;
      t_casc;
      close_out;
   end
   // cut a hang short
   initial begin
      cycles = 0;
      forever begin
         @(posedge clk);
         cycles++;
         if (cycles == 6000) begin
            n_errors++;
            close_out;
         end
      end
   end
endmodule // interrupt_ack_vector_sequencer_tb_top
